// *** sahp_port.sv ***
/*
  Digital host port of a 13-bit successive-approximation converter:
  convert start, busy, result read and offset-trim write.
  Assumes all host pins are asynchronous to clk_in; conversion results
  arrive from the converter core as a valid/ready stream.
*/
`timescale 1ns/100ps
module sahp_port #(
  parameter int CONV_CYC = sahp_pkg::CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic convert_start_n_in,
  input wire logic select_n_in,
  input wire logic read_n_in,
  input wire logic write_n_in,
  input wire logic [1:0] mode_in,
  input wire logic [12:0] result_bus_in,
  output logic [12:0] result_bus_out,
  output logic result_bus_oe_out,
  output logic busy_n_out,
  input wire logic [12:0] sample_data_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  output logic sample_start_out,
  output logic [sahp_pkg::TRIM_W-1:0] trim_out
);
  import sahp_pkg::*;

  typedef enum logic [1:0] {SAHP_IDLE, SAHP_CONV, SAHP_WAIT} sahp_st_type;

  // Two-stage synchronisers for all host pins
  logic [3:0] s1_r, s2_r, s3_r;
  logic [12:0] d1_r, d2_r;
  logic [1:0] m1_r, m2_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s1_r <= 4'hf;
      s2_r <= 4'hf;
      s3_r <= 4'hf;
      m1_r <= 2'h1;
      m2_r <= 2'h1;
      d1_r <= 13'h0000;
      d2_r <= 13'h0000;
    end else begin
      s1_r <= {write_n_in, read_n_in, select_n_in, convert_start_n_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      m1_r <= mode_in;
      m2_r <= m1_r;
      d1_r <= result_bus_in;
      d2_r <= d1_r;
    end
  end

  logic cs_fall, wr_rise, rd_act, sel;
  assign sel = ~s2_r[1];
  assign cs_fall = s3_r[0] & ~s2_r[0];
  assign wr_rise = ~s3_r[3] & s2_r[3] & ~s3_r[1];
  assign rd_act = ~s2_r[1] & ~s2_r[2];

  sahp_st_type st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic busy_n_r, busy_n_nxt;
  logic [12:0] trim_r, trim_nxt, res_r, res_nxt, pend_r, pend_nxt;
  logic oe_r, oe_nxt, start_r, start_nxt;
  logic [12:0] fifo_q;
  logic fifo_v, fifo_pop, accept;
  logic ready_r, ready_nxt;
  logic [CNT_W-1:0] lvl_r, lvl_nxt;

  // Core results queue here so a slow host never loses a sample
  sahp_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_data_in(sample_data_in),
    .wr_valid_in(accept),
    // Full is tracked by the level mirror below, so this flag is unused
    .wr_ready_out(),
    .rd_data_out(fifo_q),
    .rd_valid_out(fifo_v),
    .rd_ready_in(fifo_pop)
  );

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    busy_n_nxt = busy_n_r;
    trim_nxt = trim_r;
    res_nxt = res_r;
    pend_nxt = pend_r;
    start_nxt = 1'b0;
    fifo_pop = 1'b0;
    oe_nxt = rd_act;
    unique case (st_r)
      SAHP_IDLE: begin
        if (cs_fall) begin
          st_nxt = SAHP_CONV;
          busy_n_nxt = 1'b0;
          start_nxt = 1'b1;
          cnt_nxt = CNT_W'(CONV_CYC);
          if (m2_r == SAHP_MODE_DEFER) begin
            res_nxt = pend_r;
          end
        end else if (wr_rise && sel) begin
          // Only the low 10 bits count; upper bus bits are ignored and stored as zero
          trim_nxt = {3'h0, d2_r[TRIM_W-1:0]};
        end
      end
      SAHP_CONV: begin
        if (cnt_r > CNT_W'(1)) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          st_nxt = SAHP_WAIT;
        end
      end
      SAHP_WAIT: begin
        // End of conversion waits for the core's result
        if (fifo_v) begin
          fifo_pop = 1'b1;
          busy_n_nxt = 1'b1;
          st_nxt = SAHP_IDLE;
          pend_nxt = fifo_q;
          if (m2_r != SAHP_MODE_DEFER) begin
            res_nxt = fifo_q;
          end
        end
      end
      default: st_nxt = SAHP_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= SAHP_IDLE;
      cnt_r <= '0;
      busy_n_r <= 1'b1;
      trim_r <= TRIM_RESET;
      res_r <= RESULT_RESET;
      pend_r <= RESULT_RESET;
      oe_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      busy_n_r <= busy_n_nxt;
      trim_r <= trim_nxt;
      res_r <= res_nxt;
      pend_r <= pend_nxt;
      oe_r <= oe_nxt;
      start_r <= start_nxt;
    end
  end

  // Mirror of the queue level; ready must come from a flop, so it is
  // set from the level after this edge, never from a stale full flag
  always_comb begin
    accept = sample_valid_in && ready_r;
    lvl_nxt = lvl_r + CNT_W'(accept) - CNT_W'(fifo_pop);
    ready_nxt = lvl_nxt < CNT_W'(FIFO_DEPTH);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lvl_r <= '0;
      ready_r <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign result_bus_out = res_r;
  assign result_bus_oe_out = oe_r;
  assign busy_n_out = busy_n_r;
  assign sample_start_out = start_r;
  assign sample_ready_out = ready_r;
  assign trim_out = trim_r[TRIM_W-1:0];

  busy_fall_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_r == SAHP_IDLE && cs_fall) |=> !busy_n_out && sample_start_out)
    else $error("busy did not fall on convert start");
  busy_rise_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_r == SAHP_WAIT && fifo_v) |=> busy_n_out)
    else $error("busy did not rise at end of conversion");
  conv_len_a: assert property (@(posedge clk_in) disable iff (reset_in)
    $fell(busy_n_out) |-> !busy_n_out [*2])
    else $error("conversion too short");
  // Pins reach the enable through two sync stages and one register
  drive_a: assert property (@(posedge clk_in) disable iff (reset_in)
    result_bus_oe_out == (!$past(select_n_in, 3) && !$past(read_n_in, 3)))
    else $error("bus enable does not follow select and read");
  trim_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !busy_n_out |=> $stable(trim_out))
    else $error("trim changed during conversion");
  trim_load_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_r == SAHP_IDLE && !cs_fall && wr_rise && sel)
      |=> trim_out == $past(result_bus_in[TRIM_W-1:0], 3))
    else $error("trim not captured");
  early_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_r == SAHP_WAIT && fifo_v && m2_r == SAHP_MODE_EARLY)
      |=> result_bus_out == $past(fifo_q))
    else $error("early mode result not loaded");
  defer_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_r == SAHP_IDLE && cs_fall && m2_r == SAHP_MODE_DEFER)
      |=> result_bus_out == $past(pend_r))
    else $error("deferred result not loaded");
  conv_c: cover property (@(posedge clk_in) $rose(busy_n_out));
  defer_c: cover property (@(posedge clk_in)
    st_r == SAHP_IDLE && cs_fall && m2_r == SAHP_MODE_DEFER);
  read_c: cover property (@(posedge clk_in) $rose(result_bus_oe_out));
  write_c: cover property (@(posedge clk_in) $changed(trim_out));
endmodule : sahp_port

// *** sahp_pkg.sv ***
/*
  Shared constants for the converter host port: widths, reset values,
  conversion timing and the update-mode encoding.
  Assumes a 50 MHz system clock.
*/
package sahp_pkg;
  localparam int RESULT_W = 13;
  localparam int TRIM_W = 10;
  localparam logic [12:0] TRIM_RESET = 13'h0000;
  localparam logic [12:0] RESULT_RESET = 13'h0000;
  localparam int CLK_MHZ = 50;
  localparam int CONV_TIME_NS = 300;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    SAHP_MODE_BAD0,
    SAHP_MODE_EARLY,
    SAHP_MODE_DEFER,
    SAHP_MODE_BAD3
  } sahp_mode_type;
endpackage : sahp_pkg

// *** sahp_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module sahp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    push = wr_valid_in && (cnt_r != (AW+1)'(DEPTH));
    pop = rd_ready_in && (cnt_r != '0);
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= wr_data_in;
    end
  end

  assign wr_ready_out = cnt_r != (AW+1)'(DEPTH);
  assign rd_valid_out = cnt_r != '0;
  assign rd_data_out = mem_r[rp_r];
endmodule : sahp_fifo

// *** sahp_host.sv ***
/* Host model: convert start, result read, offset write.
   Assumes the bench clock; pins change just after rising edges. */
`timescale 1ns/100ps
module sahp_host (
  input wire logic clk_in,
  input wire logic [12:0] dev_data_in,
  input wire logic dev_oe_in,
  output logic convert_start_n_out = 1'b1,
  output logic select_n_out = 1'b1,
  output logic read_n_out = 1'b1,
  output logic write_n_out = 1'b1,
  output logic [12:0] bus_level_out
);
  logic drv = 1'b0;
  logic [12:0] hold = 13'h0000;
  // Released lines show the inverse of the last value, never a stale copy
  assign bus_level_out = dev_oe_in ? dev_data_in : drv ? hold : ~hold;
  task automatic convert();
    repeat (4) @(posedge clk_in);
    convert_start_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    convert_start_n_out <= 1'b1;
  endtask : convert
  task automatic write_word(input logic [9:0] v);
    @(posedge clk_in);
    hold <= {3'b000, v};
    drv <= 1'b1;
    select_n_out <= 1'b0;
    write_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    write_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    select_n_out <= 1'b1;
    drv <= 1'b0;
  endtask : write_word
  task automatic read_word(output logic [12:0] v);
    int n = 0;
    @(posedge clk_in);
    select_n_out <= 1'b0;
    read_n_out <= 1'b0;
    while (dev_oe_in !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    @(posedge clk_in);
    v = bus_level_out;
    select_n_out <= 1'b1;
    read_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask : read_word
endmodule : sahp_host

// *** sar_adc_host_port_offset_write_bench.sv ***
/* Self-checking bench for the converter host port.
   Assumes sahp_pkg, sahp_port, sahp_fifo and sahp_host are compiled. */
`timescale 1ns/100ps
module sar_adc_host_port_offset_write_bench;
  import sahp_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] mode_in = 2'b01;
  logic [12:0] s_data = 13'h0000;
  logic s_valid = 1'b0;
  logic cv_n, cs_n, rd_n, wr_n, oe, busy_n, s_ready, s_start;
  logic [12:0] bus, dout, rv;
  logic [9:0] trim;
  logic [9:0] vals [4] = '{10'h2B9, 10'h380, 10'h040, 10'h147};
  logic [1:0] codes [3] = '{2'b01, 2'b00, 2'b11};
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int starts = 0;
  sahp_port #(.CONV_CYC(4)) i_sahp_port (.clk_in(clk_in),
    .reset_in(reset_in), .convert_start_n_in(cv_n), .select_n_in(cs_n),
    .read_n_in(rd_n), .write_n_in(wr_n), .mode_in(mode_in),
    .result_bus_in(bus), .result_bus_out(dout), .result_bus_oe_out(oe),
    .busy_n_out(busy_n), .sample_data_in(s_data),
    .sample_valid_in(s_valid), .sample_ready_out(s_ready),
    .sample_start_out(s_start), .trim_out(trim));
  sahp_host i_sahp_host (.clk_in(clk_in), .dev_data_in(dout),
    .dev_oe_in(oe), .convert_start_n_out(cv_n), .select_n_out(cs_n),
    .read_n_out(rd_n), .write_n_out(wr_n), .bus_level_out(bus));
  initial forever #10 clk_in = ~clk_in;
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Timeout also ends any stuck handshake wait
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    // A start pulse longer than one cycle counts once per cycle high
    if (s_start === 1'b1) begin
      starts <= starts + 1;
    end
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic fill(input int n, input logic [12:0] base);
    s_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      s_data <= base + 13'(i);
      do @(posedge clk_in); while (s_ready !== 1'b1);
    end
    s_valid <= 1'b0;
  endtask : fill
  task automatic done_read(input logic [12:0] exp);
    int n = 0;
    while (busy_n !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    check(13'(busy_n), 13'h0001);
    i_sahp_host.read_word(rv);
    check(rv, exp);
    check(13'(oe), 13'h0000);
  endtask : done_read
  task automatic t_trim();
    for (int i = 0; i < 4; i++) begin
      i_sahp_host.write_word(vals[i]);
      check(13'(trim), 13'(vals[i]));
    end
  endtask : t_trim
  task automatic t_fill();
    fill(16, 13'h0100);
    repeat (3) @(posedge clk_in);
    check(13'(s_ready), 13'h0000);
    for (int i = 0; i < 16; i++) begin
      mode_in <= codes[i % 3];
      i_sahp_host.convert();
      done_read(13'h0100 + 13'(i));
    end
    check(13'(trim), 13'h0147);
    check(13'(starts), 13'h0010);
  endtask : t_fill
  task automatic t_defer();
    mode_in <= 2'b10;
    fill(1, 13'h0AAA);
    i_sahp_host.convert();
    done_read(13'h010F);
    fill(1, 13'h0555);
    i_sahp_host.convert();
    done_read(13'h0AAA);
  endtask : t_defer
  task automatic t_refuse();
    mode_in <= 2'b01;
    i_sahp_host.convert();
    repeat (20) @(posedge clk_in);
    check(13'(busy_n), 13'h0000);
    i_sahp_host.convert();
    i_sahp_host.write_word(10'h001);
    check(13'(trim), 13'h0147);
    fill(1, 13'h1234);
    done_read(13'h1234);
    repeat (10) @(posedge clk_in);
    check(13'(busy_n), 13'h0001);
    check(13'(starts), 13'h0013);
  endtask : t_refuse
  task automatic t_reset();
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({oe, busy_n, 1'b0, trim}, 13'h0800);
    check(dout, RESULT_RESET);
  endtask : t_reset
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({oe, busy_n, 1'b0, trim}, 13'h0800);
    check(dout, RESULT_RESET);
    t_trim();
    t_fill();
    t_defer();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule : sar_adc_host_port_offset_write_bench
